/* File: rtl/rsc_pkg.sv */
`default_nettype none
package rsc_pkg;
   // register offsets (byte addresses)
   localparam logic [11:0] RSC_CAUSE_OFF   = 12'h000;
   localparam logic [11:0] RSC_FUSE_OFF    = 12'h004;
   localparam logic [11:0] RSC_REFCTL_OFF  = 12'h008;
   localparam logic [11:0] RSC_STATE_OFF   = 12'h00c;
   // reset cause fields
   localparam int RSC_WDT_BIT = 3;
   localparam int RSC_BOR_BIT = 2;
   localparam int RSC_EXT_BIT = 1;
   localparam int RSC_POR_BIT = 0;
   localparam logic [3:0] RSC_CAUSE_RST = 4'h1;
   // reference control fields
   localparam int RSC_COMPARATOR_BANDGAP_SELECT_BIT = 0;
   localparam int RSC_ADC_BIT  = 1;
   localparam int RSC_DAC_BIT  = 2;
   // brown-out fuse code that disables detection
   localparam logic [2:0] RSC_BOD_OFF = 3'h7;
   // timing
   localparam int RSC_CLK_NS      = 40;
   localparam int RSC_PIN_MIN_NS  = 400;
   localparam int RSC_BOD_MIN_NS  = 2000;
   localparam int RSC_PIN_CYC     = (RSC_PIN_MIN_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
   localparam int RSC_BOD_CYC     = (RSC_BOD_MIN_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
   localparam int RSC_REF_US      = 40;
   // start-up delay base, cycles, shifted left by {startup, clock select low bits}
   localparam int RSC_DLY_W       = 16;
   localparam logic [RSC_DLY_W-1:0] RSC_DLY_BASE = 16'h0010;
   localparam logic [5:0] RSC_FUSE_RST = 6'h00;
endpackage : rsc_pkg
`default_nettype wire

/* File: rtl/rsc_filter.sv */
`default_nettype none
// qualifies a synchronised level: output follows only after it held for CYC cycles
module rsc_filter
   import rsc_pkg::*;
#(
   parameter int CYC = 10
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // level in and out
   input  wire logic lvl_in,
   output logic      lvl_out
);
   localparam int CW = $clog2(CYC + 1);
   logic [CW-1:0] cnt_r;
   logic          out_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         out_r <= 1'b0;
      end else if (lvl_in == out_r) begin
         cnt_r <= '0;
      end else if (cnt_r == CW'(CYC - 1)) begin
         cnt_r <= '0;
         out_r <= lvl_in;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign lvl_out = out_r;
endmodule : rsc_filter
`default_nettype wire

/* File: rtl/rsc_sync.sv */
`default_nettype none
// two-flop synchroniser for asynchronous levels
module rsc_sync (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // level
   input  wire logic d,
   output logic      q
);
   logic meta_r;
   logic q_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 1'b0;
         q_r    <= 1'b0;
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

   assign q = q_r;
endmodule : rsc_sync
`default_nettype wire

/* File: rtl/rsc_reset_source_controller.sv */
// Functional notes
// - internal reset drives core and I/O registers; core starts at reset vector after
// - port reset asserts combinationally from power-on, pin and watchdog, no clock needed; brown-out only through its clocked filter
// - after all sources inactive, delay counter stretches reset by fuse-chosen period
// - four causes: power-on, pin, enabled watchdog, enabled brown-out
// - pin low beyond minimum width resets through the clocked filter; without clock only port reset asserts
// - pin release starts the delay counter, reset ends when it expires
// - power-on reset asserts immediately whenever supply is below threshold
// - supply reaching power-on threshold starts the delay counter
// - three-bit brown-out fuse, all-ones disables detection
// - brown-out asserts reset after synchroniser and filter, releases through delay counter
// - brown-out only counts when held past minimum duration
// - watchdog timeout gives one-cycle pulse; delay starts on its falling edge
// - watchdog flag bit 3: set by watchdog, cleared by power-on or zero write
// - brown-out flag bit 2: set by brown-out, cleared by power-on or zero write
// - pin flag bit 1: set by pin reset, cleared by power-on or zero write
// - power-on flag bit 0: set by power-on, cleared only by zero write
// - bandgap on when brown-out, comparator select, converter or DAC enabled
`default_nettype none
module rsc_reset_source_controller
   import rsc_pkg::*;
#(
   parameter int PIN_CYC = RSC_PIN_CYC,
   parameter int BOD_CYC = RSC_BOD_CYC
) (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // reset sources
   input  wire logic        supply_below_por,
   input  wire logic        supply_below_bot,
   input  wire logic        reset_pin_n,
   input  wire logic        wdt_timeout,
   input  wire logic        wdt_enabled,
   // fuses
   input  wire logic [2:0]  brownout_level_fuses,
   input  wire logic [1:0]  startup_time_fuses,
   input  wire logic [3:0]  clock_select_fuses,
   // reset outputs
   output logic             sys_reset,
   output logic             port_reset,
   output logic             bandgap_on
);
   logic pin_low_s, bot_s;
   logic pin_rst, bod_rst;
   logic bod_en;
   logic wdt_pulse;
   logic por_seen_r;
   logic [3:0] cause_r;
   logic [2:0] refctl_r;
   logic [RSC_DLY_W-1:0] dly_r;
   logic [RSC_DLY_W-1:0] dly_len;
   logic src_act;
   logic wr_ok, rd_ok;

   // time-qualified pin level, synchronised first
   rsc_sync u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (~reset_pin_n),
      .q       (pin_low_s)
   );
   rsc_filter #(.CYC(PIN_CYC)) u_pin_flt (
      .pclk    (pclk),
      .presetn (presetn),
      .lvl_in  (pin_low_s),
      .lvl_out (pin_rst)
   );

   rsc_sync u_bot_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (supply_below_bot),
      .q       (bot_s)
   );
   rsc_filter #(.CYC(BOD_CYC)) u_bot_flt (
      .pclk    (pclk),
      .presetn (presetn),
      .lvl_in  (bot_s & bod_en),
      .lvl_out (bod_rst)
   );

   assign bod_en = (brownout_level_fuses != RSC_BOD_OFF);

   // watchdog only counts when enabled; a one-cycle pulse, delay starts after it
   assign wdt_pulse = wdt_timeout & wdt_enabled;

   // power-on is the async clear of the whole block; presetn is taken to be the
   // por comparator combined by the system, so supply_below_por feeds it too
   assign src_act = supply_below_por | pin_rst | bod_rst | wdt_pulse;

   // stretch length from fuses; a limitation: base shifted left by the code, not a lookup
   // codes that would shift the base out of the counter saturate instead of giving zero
   assign dly_len = ({startup_time_fuses, clock_select_fuses[1:0]} >= 4'hc) ? '1 :
                    RSC_DLY_BASE << {startup_time_fuses, clock_select_fuses[1:0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_r <= RSC_DLY_BASE;
      end else if (src_act) begin
         dly_r <= dly_len;
      end else if (dly_r != '0) begin
         dly_r <= dly_r - 1'b1;
      end
   end

   // any source or a running counter keeps reset; the async terms need no clock
   assign sys_reset  = ~presetn | supply_below_por | src_act | (dly_r != '0);
   assign port_reset = ~presetn | supply_below_por | ~reset_pin_n | src_act;

   assign bandgap_on = bod_en | refctl_r[RSC_COMPARATOR_BANDGAP_SELECT_BIT] | refctl_r[RSC_ADC_BIT]
                     | refctl_r[RSC_DAC_BIT];

   // apb: zero wait states, unmapped offsets answer pslverr
   assign pready = 1'b1;
   assign wr_ok  = psel & penable & pwrite;
   assign rd_ok  = psel & ~penable & ~pwrite;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == RSC_CAUSE_OFF) | (a == RSC_FUSE_OFF) |
               (a == RSC_REFCTL_OFF) | (a == RSC_STATE_OFF);
   endfunction : mapped

   assign pslverr = psel & penable & ~mapped(paddr);

   // power-on flag follows presetn: por_seen_r reloads the cause reset value on the first clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_seen_r <= 1'b1;
      end else begin
         por_seen_r <= 1'b0;
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_r <= RSC_CAUSE_RST;
      end else begin
         if (wr_ok && paddr == RSC_CAUSE_OFF) begin
            cause_r <= cause_r & pwdata[3:0];
         end
         if (wdt_pulse) cause_r[RSC_WDT_BIT] <= 1'b1;
         if (bod_rst)   cause_r[RSC_BOR_BIT] <= 1'b1;
         if (pin_rst)   cause_r[RSC_EXT_BIT] <= 1'b1;
         if (supply_below_por || por_seen_r) begin
            cause_r <= RSC_CAUSE_RST;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refctl_r <= '0;
      end else if (wr_ok && paddr == RSC_REFCTL_OFF) begin
         refctl_r <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_ok) begin
         unique case (paddr)
            RSC_CAUSE_OFF:  prdata <= {28'h0, cause_r};
            RSC_FUSE_OFF:   prdata <= {23'h0, brownout_level_fuses, startup_time_fuses,
                                       clock_select_fuses};
            RSC_REFCTL_OFF: prdata <= {28'h0, bandgap_on, refctl_r};
            RSC_STATE_OFF:  prdata <= {12'h0, bod_rst, pin_rst, bod_en, sys_reset, dly_r};
            default:        prdata <= '0;
         endcase
      end
   end

   AST_WDT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_pulse && !supply_below_por && !por_seen_r |=> cause_r[RSC_WDT_BIT])
      else $error("watchdog flag not set");
   AST_BOR_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      bod_rst && !supply_below_por && !por_seen_r |=> cause_r[RSC_BOR_BIT])
      else $error("brown-out flag not set");
   AST_EXT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      pin_rst && !supply_below_por && !por_seen_r |=> cause_r[RSC_EXT_BIT])
      else $error("pin flag not set");
   AST_POR_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      supply_below_por |=> cause_r == RSC_CAUSE_RST)
      else $error("power-on did not set flags");
   AST_SRC_RST: assert property (@(posedge pclk) disable iff (!presetn)
      src_act |-> sys_reset && port_reset)
      else $error("source active without reset");
   AST_STRETCH: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(src_act) |-> sys_reset [*2])
      else $error("reset not stretched");
   AST_BOD_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !bod_en |-> ##[0:3] !bod_rst || bod_en)
      else $error("brown-out reset while disabled");
   AST_BANDGAP: assert property (@(posedge pclk) disable iff (!presetn)
      bod_en |-> bandgap_on)
      else $error("bandgap off with brown-out enabled");
   AST_PORT: assert property (@(posedge pclk) disable iff (!presetn)
      !reset_pin_n |-> port_reset)
      else $error("port reset missing");

   COV_WDT: cover property (@(posedge pclk) disable iff (!presetn) wdt_pulse);
   COV_PIN: cover property (@(posedge pclk) disable iff (!presetn) $rose(pin_rst));
   COV_BOD: cover property (@(posedge pclk) disable iff (!presetn) $rose(bod_rst));
   COV_REL: cover property (@(posedge pclk) disable iff (!presetn) $fell(sys_reset));
endmodule : rsc_reset_source_controller
`default_nettype wire

/* File: tb/rsc_src_model.sv */
`default_nettype none
// supply monitors, reset pin and watchdog, driven on pclk edges
module rsc_src_model (
   // clock
   input  wire logic pclk,
   // sources
   output logic      supply_below_por,
   output logic      supply_below_bot,
   output logic      reset_pin_n,
   output logic      wdt_timeout
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      supply_below_por = 1'b0;
      supply_below_bot = 1'b0;
      reset_pin_n      = 1'b1;
      wdt_timeout      = 1'b0;
   end
   // one source active for n cycles; n=1 on the watchdog is its single pulse
   task automatic hold(input int src, input int n);
      @(posedge pclk);
      case (src)
         0: supply_below_por <= 1'b1;
         1: supply_below_bot <= 1'b1;
         2: reset_pin_n <= 1'b0;
         default: wdt_timeout <= 1'b1;
      endcase
      repeat (n) @(posedge pclk);
      supply_below_por <= 1'b0;
      supply_below_bot <= 1'b0;
      reset_pin_n      <= 1'b1;
      wdt_timeout      <= 1'b0;
   endtask : hold
endmodule : rsc_src_model
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top import rsc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        supply_below_por, supply_below_bot, reset_pin_n, wdt_timeout;
   logic        wdt_enabled, sys_reset, port_reset, bandgap_on, e;
   logic [2:0]  brownout_level_fuses;
   logic [1:0]  startup_time_fuses;
   logic [3:0]  clock_select_fuses;
   int          n_errors, tests_run, i;
   rsc_reset_source_controller #(.PIN_CYC(2), .BOD_CYC(4)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .supply_below_por, .supply_below_bot, .reset_pin_n,
      .wdt_timeout, .wdt_enabled, .brownout_level_fuses, .startup_time_fuses,
      .clock_select_fuses, .sys_reset, .port_reset, .bandgap_on);
   rsc_src_model src_u (.pclk, .supply_below_por, .supply_below_bot, .reset_pin_n,
      .wdt_timeout);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic fail(input string m);
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
   endtask : fail
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) fail($sformatf("got %h expected %h", g, x));
   endtask : cmp
   task automatic cmp_rng(input int g, input int lo, input int hi);
      tests_run++;
      if (g < lo || g > hi) fail($sformatf("count %0d not in %0d..%0d", g, lo, hi));
   endtask : cmp_rng
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         fail("no pready");
         end_of_test();
      end
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      cmp(r, x);
   endtask : rd
   // counts reset cycles after the last source let go
   task automatic wait_rel(input int d);
      int c;
      c = 0;
      while (sys_reset !== 1'b0 && c < 3000) begin
         @(posedge pclk);
         c++;
      end
      if (c == 3000) begin
         fail("reset never released");
         end_of_test();
      end
      cmp_rng(c, d, d + 10);
   endtask : wait_rel
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   initial begin
      {presetn, psel, penable, pwrite, wdt_enabled} = 5'h00;
      {paddr, pwdata} = 44'h0;
      brownout_level_fuses = 3'h6;
      startup_time_fuses   = 2'h0;
      clock_select_fuses   = 4'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      wait_rel(16);
      rd(RSC_CAUSE_OFF, 32'h1);
      rd(RSC_FUSE_OFF, 32'h180);
      apb(1'b1, RSC_FUSE_OFF, 32'h0);
      rd(RSC_FUSE_OFF, 32'h180);
      apb(1'b1, 12'h010, 32'hf);
      cmp({31'h0, e}, 32'h1);
      rd(12'h010, 32'h0);
      apb(1'b1, RSC_CAUSE_OFF, 32'h0);
      rd(RSC_CAUSE_OFF, 32'h0);
      cmp({31'h0, bandgap_on}, 32'h1);
      $display("test registers done");
      fork
         src_u.hold(2, 8);
         begin
            @(posedge pclk);
            #1 cmp({31'h0, port_reset}, 32'h1);
         end
      join
      wait_rel(16);
      rd(RSC_CAUSE_OFF, 32'h2);
      $display("test pin done");
      @(posedge pclk);
      clock_select_fuses <= 4'h1;
      wdt_enabled        <= 1'b1;
      src_u.hold(3, 1);
      #1 cmp({31'h0, sys_reset}, 32'h1);
      wait_rel(32);
      rd(RSC_CAUSE_OFF, 32'ha);
      apb(1'b1, RSC_CAUSE_OFF, 32'h8);
      rd(RSC_CAUSE_OFF, 32'h8);
      @(posedge pclk);
      wdt_enabled <= 1'b0;
      src_u.hold(3, 1);
      repeat (4) @(posedge pclk);
      #1 cmp({31'h0, sys_reset}, 32'h0);
      $display("test watchdog done");
      src_u.hold(1, 3);
      repeat (8) @(posedge pclk);
      #1 cmp({31'h0, sys_reset}, 32'h0);
      src_u.hold(1, 12);
      wait_rel(32);
      rd(RSC_CAUSE_OFF, 32'hc);
      @(posedge pclk);
      brownout_level_fuses <= 3'h7;
      src_u.hold(1, 12);
      #1 cmp({31'h0, sys_reset | bandgap_on}, 32'h0);
      for (i = 0; i < 3; i++) begin
         apb(1'b1, RSC_REFCTL_OFF, 32'h1 << i);
         rd(RSC_REFCTL_OFF, (32'h1 << i) | 32'h8);
         cmp({31'h0, bandgap_on}, 32'h1);
      end
      apb(1'b1, RSC_REFCTL_OFF, 32'h0);
      rd(RSC_REFCTL_OFF, 32'h0);
      $display("test brown-out and reference done");
      fork
         src_u.hold(0, 4);
         begin
            @(posedge pclk);
            #1 cmp({30'h0, sys_reset, port_reset}, 32'h3);
         end
      join
      wait_rel(32);
      rd(RSC_CAUSE_OFF, 32'h1);
      $display("test power-on done");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
